// ---- adc_cfg_pkg.sv ----
// shared constants and carrier types for the converter configuration block
package adc_cfg_pkg;

  // serial frame geometry
  localparam int unsigned FRAME_BITS   = 16;
  localparam int unsigned ADDR_MSB     = 15;
  localparam int unsigned ADDR_LSB     = 8;

  // register addresses
  localparam logic [7:0] ADDR_REF_SEL    = 8'h6d;
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h6e;
  localparam logic [7:0] ADDR_BUF_CURR   = 8'h7e;
  localparam logic [7:0] ADDR_CURR_MULT  = 8'h7f;

  // field positions
  localparam int unsigned REF_SEL_BIT     = 4;
  localparam int unsigned SOFT_RESET_BIT  = 0;
  localparam int unsigned CURR_LSB        = 0;
  localparam int unsigned CLK_TERM_LSB    = 2;
  localparam int unsigned DATA_TERM_LSB   = 5;
  localparam int unsigned MULT_LSB        = 6;

  // reset values
  localparam logic [7:0] REF_SEL_RST    = 8'h00;
  localparam logic [7:0] BUF_CURR_RST   = 8'h00;
  localparam logic [7:0] CURR_MULT_RST  = 8'h00;

  // buffer current codes
  localparam logic [1:0] CURR_3P5MA  = 2'h0;
  localparam logic [1:0] CURR_2P5MA  = 2'h1;
  localparam logic [1:0] CURR_4P5MA  = 2'h2;
  localparam logic [1:0] CURR_1P75MA = 2'h3;

  // termination off code
  localparam logic [2:0] TERM_NONE = 3'h0;

  // multiplier codes
  typedef enum logic [1:0] {
    MULT_1X     = 2'b00,
    MULT_2X_ALL = 2'b01,
    MULT_2X_CLK = 2'b10,
    MULT_2X_4X  = 2'b11
  } curr_mult_t;

  // settings that steer the output stage
  typedef struct packed {
    logic       ext_ref;       // external reference active
    logic [1:0] curr_code;     // base buffer current code
    logic [2:0] clk_term;      // clock output termination code
    logic [2:0] data_term;     // data output termination code
    logic [1:0] data_scale;    // data current multiplier, log2
    logic [1:0] clk_scale;     // clock current multiplier, log2
    logic       low_rate;      // low sampling rate mode
    logic       standby;       // standby
    logic       clk_edge_alt;  // alternate output clock edge
  } cfg_t;

  // one decoded serial write
  typedef struct packed {
    logic [7:0] addr;  // register address
    logic [7:0] data;  // register data
  } ser_word_t;

endpackage : adc_cfg_pkg

// ---- adc_config_and_pin_control.sv ----
// configuration registers and dual-use control pins of the converter
// Behaviour
// - ref bit selects internal or external reference
// - writing D0 of 6E restores defaults
// - 7E D1-D0 selects buffer current
// - 7E D4-D2 sets clock termination
// - 7E D7-D5 sets data termination
// - 7F D7-D6 scales buffer currents
// - clock pin is shift clock or rate control
// - data pin is serial data or standby
// - select pin is frame enable or clock edge
// - outputs driven only while enable high
// - format pin picks coding and interface
// - mode pin picks reference when pin-driven
// - differential mode sends bit pairs on lanes
// - cmos mode: sixteen pins, single clock
// - out-of-range flag in both modes
// - frame is address byte then data
// - sample on falling clock while select low
// - software reset bit clears itself
`timescale 1ns/1ps
module adc_config_and_pin_control (
  input  wire logic                clk_sys_in,
  input  wire logic                rst_b_in,
  input  wire logic                sclk_in,
  input  wire logic                ser_reset_in,
  input  wire logic                serial_shift_data_in,
  input  wire logic                serial_frame_select_n_in,
  input  wire logic                out_enable_in,
  input  wire logic                format_and_interface_select_in,
  input  wire logic                ref_mode_pin_in,
  input  wire logic [15:0]         sample_in,
  input  wire logic                sample_ovr_in,
  output adc_cfg_pkg::cfg_t        cfg_out,
  output logic                     offset_binary_out,
  output logic                     cmos_mode_out,
  output logic [7:0]               ddr_lane_rise_out,
  output logic [7:0]               ddr_lane_fall_out,
  output logic [7:0]               ddr_lane_oe_out,
  output logic [15:0]              cmos_data_out,
  output logic [15:0]              cmos_data_oe_out,
  output logic                     clk_out_oe_out,
  output logic                     clk_out_comp_oe_out,
  output logic                     out_of_range_flag_out,
  output logic                     out_of_range_flag_oe_out,
  output logic                     common_mode_pin_is_input_out
);

  // synchronised pins
  logic reset_pin_s;   // reset pin level
  logic sclk_s;        // clock pin as static level
  logic serial_shift_data_s;       // data pin as static level
  logic sel_s;         // select pin as static level
  logic oe_s;          // output enable level
  logic fmt_s;         // format pin level
  logic ref_pin_s;     // reference pin level
  logic tgl_s;         // word toggle, synchronised
  logic tgl_d_r;       // previous toggle value

  adc_cfg_pkg::ser_word_t word_link;  // word on link clock
  logic                   word_tgl;   // word event toggle
  adc_cfg_pkg::ser_word_t word_r;     // word in system domain
  logic                   word_vld;   // new word this cycle

  // registers
  logic [7:0] ref_sel_r;    // reference select register
  logic [7:0] buf_curr_r;   // current and termination register
  logic [7:0] curr_mult_r;  // current multiplier register
  logic       soft_rst_r;   // software reset bit, self clearing

  // the link-side serial shifter; gated off when the pins are static
  serial_shift u_shift (
    .sclk_in                  (sclk_in),
    .rst_b_in                 (rst_b_in),
    .serial_frame_select_n_in (serial_frame_select_n_in | ser_reset_in),
    .serial_shift_data_in     (serial_shift_data_in),
    .word_out                 (word_link),
    .word_tgl_out             (word_tgl)
  );

  // pin synchronisers, one per static pin, plus one for the word toggle
  bit_sync u_s_rst  (.clk_in(clk_sys_in), .rst_b_in(rst_b_in), .d_in(ser_reset_in),
                     .q_out(reset_pin_s));
  bit_sync u_s_sclk (.clk_in(clk_sys_in), .rst_b_in(rst_b_in), .d_in(sclk_in),
                     .q_out(sclk_s));
  bit_sync u_s_sdat (.clk_in(clk_sys_in), .rst_b_in(rst_b_in), .d_in(serial_shift_data_in),
                     .q_out(serial_shift_data_s));
  bit_sync #(.RST_VAL(1'b1)) u_s_sel (.clk_in(clk_sys_in), .rst_b_in(rst_b_in),
                     .d_in(serial_frame_select_n_in), .q_out(sel_s));
  bit_sync u_s_oe   (.clk_in(clk_sys_in), .rst_b_in(rst_b_in), .d_in(out_enable_in),
                     .q_out(oe_s));
  bit_sync u_s_fmt  (.clk_in(clk_sys_in), .rst_b_in(rst_b_in),
                     .d_in(format_and_interface_select_in), .q_out(fmt_s));
  bit_sync u_s_ref  (.clk_in(clk_sys_in), .rst_b_in(rst_b_in), .d_in(ref_mode_pin_in),
                     .q_out(ref_pin_s));
  bit_sync u_s_tgl  (.clk_in(clk_sys_in), .rst_b_in(rst_b_in), .d_in(word_tgl),
                     .q_out(tgl_s));

  // toggle edge detect on the synchronised copy
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tgl_d_r <= 1'b0;
    end else begin
      tgl_d_r <= tgl_s;
    end
  end

  assign word_vld = tgl_s ^ tgl_d_r;

  // capture the word; it changed on the same shift clock edge as the toggle and has been stable since
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      word_r <= '0;
    end else if (tgl_s != tgl_d_r) begin
      word_r <= word_link;
    end
  end

  logic wr_pend_r;  // word captured, apply next cycle
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_pend_r <= 1'b0;
    end else begin
      wr_pend_r <= word_vld;
    end
  end

  // software reset trigger; clears itself one cycle later
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      soft_rst_r <= 1'b0;
    end else if (wr_pend_r && word_r.addr == adc_cfg_pkg::ADDR_SOFT_RESET) begin
      soft_rst_r <= word_r.data[adc_cfg_pkg::SOFT_RESET_BIT];
    end else begin
      soft_rst_r <= 1'b0;
    end
  end

  // register writes; pin reset pulse or soft reset restore defaults
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ref_sel_r   <= adc_cfg_pkg::REF_SEL_RST;
      buf_curr_r  <= adc_cfg_pkg::BUF_CURR_RST;
      curr_mult_r <= adc_cfg_pkg::CURR_MULT_RST;
    end else if (soft_rst_r || reset_pin_s) begin
      ref_sel_r   <= adc_cfg_pkg::REF_SEL_RST;
      buf_curr_r  <= adc_cfg_pkg::BUF_CURR_RST;
      curr_mult_r <= adc_cfg_pkg::CURR_MULT_RST;
    end else if (wr_pend_r) begin
      unique case (word_r.addr)
        adc_cfg_pkg::ADDR_REF_SEL:   ref_sel_r   <= word_r.data;
        adc_cfg_pkg::ADDR_BUF_CURR:  buf_curr_r  <= word_r.data;
        adc_cfg_pkg::ADDR_CURR_MULT: curr_mult_r <= word_r.data;
        default:                     ;  // other addresses ignored
      endcase
    end
  end

  // settings mux
  adc_cfg_pkg::cfg_t cfg_nxt;
  logic [1:0]        mult;
  always_comb begin
    cfg_nxt = '0;
    mult    = curr_mult_r[adc_cfg_pkg::MULT_LSB +: 2];
    cfg_nxt.curr_code = buf_curr_r[adc_cfg_pkg::CURR_LSB +: 2];
    cfg_nxt.clk_term  = buf_curr_r[adc_cfg_pkg::CLK_TERM_LSB +: 3];
    cfg_nxt.data_term = buf_curr_r[adc_cfg_pkg::DATA_TERM_LSB +: 3];
    unique case (mult)
      adc_cfg_pkg::MULT_1X:     begin cfg_nxt.data_scale = 2'd0; cfg_nxt.clk_scale = 2'd0; end
      adc_cfg_pkg::MULT_2X_ALL: begin cfg_nxt.data_scale = 2'd1; cfg_nxt.clk_scale = 2'd1; end
      adc_cfg_pkg::MULT_2X_CLK: begin cfg_nxt.data_scale = 2'd0; cfg_nxt.clk_scale = 2'd1; end
      adc_cfg_pkg::MULT_2X_4X:  begin cfg_nxt.data_scale = 2'd1; cfg_nxt.clk_scale = 2'd2; end
    endcase
    // static pins rule while reset pin is high
    if (reset_pin_s) begin
      cfg_nxt.ext_ref      = ref_pin_s;
      // clock pin as low rate control
      cfg_nxt.low_rate     = sclk_s;
      cfg_nxt.standby      = serial_shift_data_s;
      // select pin as clock edge choice
      cfg_nxt.clk_edge_alt = sel_s;
    end else begin
      cfg_nxt.ext_ref      = ref_sel_r[adc_cfg_pkg::REF_SEL_BIT];
    end
  end

  // registered settings out
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cfg_out                      <= '0;
      common_mode_pin_is_input_out <= 1'b0;
    end else begin
      cfg_out                      <= cfg_nxt;
      common_mode_pin_is_input_out <= cfg_nxt.ext_ref;
    end
  end

  // format pin picks coding and interface
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      offset_binary_out <= 1'b0;
      cmos_mode_out     <= 1'b0;
    end else begin
      offset_binary_out <= fmt_s;
      cmos_mode_out     <= fmt_s;
    end
  end

  // output data path, coded per format
  logic [15:0] coded;
  assign coded = fmt_s ? {~sample_in[15], sample_in[14:0]} : sample_in;

  // lane pairs, even bit on rise, odd bit on fall
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_lane
      always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          ddr_lane_rise_out[g] <= 1'b0;
          ddr_lane_fall_out[g] <= 1'b0;
        end else begin
          ddr_lane_rise_out[g] <= coded[2*g];
          ddr_lane_fall_out[g] <= coded[2*g+1];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cmos_data_out         <= '0;
      out_of_range_flag_out <= 1'b0;
    end else begin
      cmos_data_out         <= coded;
      out_of_range_flag_out <= sample_ovr_in;
    end
  end

  // enables follow output enable and mode
  always_comb begin
    ddr_lane_oe_out          = (oe_s && !cmos_mode_out) ? 8'hff : 8'h00;
    cmos_data_oe_out         = (oe_s && cmos_mode_out) ? 16'hffff : 16'h0000;
    clk_out_oe_out           = oe_s;
    clk_out_comp_oe_out      = oe_s && !cmos_mode_out;
    out_of_range_flag_oe_out = oe_s;
  end

  // assertions
  property p_soft_clear;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
      soft_rst_r |=> !soft_rst_r;
  endproperty
  a_soft_clear: assert property (p_soft_clear) else $error("soft reset stuck");

  property p_soft_default;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
      soft_rst_r |=> (buf_curr_r == adc_cfg_pkg::BUF_CURR_RST
                      && curr_mult_r == adc_cfg_pkg::CURR_MULT_RST);
  endproperty
  a_soft_default: assert property (p_soft_default) else $error("defaults lost");

  property p_curr;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
      1'b1 |=> cfg_out.curr_code == $past(buf_curr_r[1:0]);
  endproperty
  a_curr: assert property (p_curr) else $error("current code wrong");

  property p_clk_term;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
      1'b1 |=> cfg_out.clk_term == $past(buf_curr_r[4:2]);
  endproperty
  a_clk_term: assert property (p_clk_term) else $error("clock term wrong");

  property p_data_term;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
      1'b1 |=> cfg_out.data_term == $past(buf_curr_r[7:5]);
  endproperty
  a_data_term: assert property (p_data_term) else $error("data term wrong");

  property p_mult4;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
      (curr_mult_r[7:6] == 2'b11) |=> (cfg_out.clk_scale == 2'd2 && cfg_out.data_scale == 2'd1);
  endproperty
  a_mult4: assert property (p_mult4) else $error("multiplier wrong");

  property p_oe;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
      !oe_s |-> (ddr_lane_oe_out == 8'h00 && cmos_data_oe_out == 16'h0000 && !clk_out_oe_out);
  endproperty
  a_oe: assert property (p_oe) else $error("driving while disabled");

  property p_static_standby;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
      reset_pin_s |=> cfg_out.standby == $past(serial_shift_data_s);
  endproperty
  a_static_standby: assert property (p_static_standby) else $error("standby pin ignored");

  property p_ref_reg;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
      !reset_pin_s |=> cfg_out.ext_ref == $past(ref_sel_r[4]);
  endproperty
  a_ref_reg: assert property (p_ref_reg) else $error("reference select wrong");

  property p_static_pins;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
      reset_pin_s |=> (cfg_out.clk_edge_alt == $past(sel_s)
                       && cfg_out.low_rate == $past(sclk_s));
  endproperty
  a_static_pins: assert property (p_static_pins) else $error("static pins ignored");

  property p_serial_pins;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
      !reset_pin_s |=> (!cfg_out.low_rate && !cfg_out.standby && !cfg_out.clk_edge_alt);
  endproperty
  a_serial_pins: assert property (p_serial_pins) else $error("pin levels leak");

  property p_fmt;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
      1'b1 |=> (cmos_mode_out == $past(fmt_s) && offset_binary_out == $past(fmt_s));
  endproperty
  a_fmt: assert property (p_fmt) else $error("format pin ignored");

  property p_cmos_clk;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
      cmos_mode_out |-> (!clk_out_comp_oe_out && ddr_lane_oe_out == 8'h00);
  endproperty
  a_cmos_clk: assert property (p_cmos_clk) else $error("complement clock driven");

  // a buffer register write with no restore pending
  sequence s_buf_word;
    wr_pend_r && word_r.addr == adc_cfg_pkg::ADDR_BUF_CURR;
  endsequence
  sequence s_no_restore;
    !soft_rst_r && !reset_pin_s;
  endsequence
  property p_buf_write;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
      (s_buf_word and s_no_restore) |=> buf_curr_r == $past(word_r.data);
  endproperty
  a_buf_write: assert property (p_buf_write) else $error("register write lost");

endmodule : adc_config_and_pin_control

// ---- adc_config_and_pin_control_tb.sv ----
// self-checking bench for the converter configuration block
`timescale 1ns/1ps
module adc_config_and_pin_control_tb;
  logic              clk_sys_in = 1'b0;  // system clock
  logic              rst_b_in = 1'b0;    // system reset
  logic              sclk, serial_shift_data, sen_n; // host serial pins
  logic              rst_pin;            // host reset pin
  logic              oe = 1'b0;          // output enable pin
  logic              fmt = 1'b0;         // format pin
  logic              mode_pin = 1'b0;    // reference pin
  logic [15:0]       smp = 16'h0000;     // converter word
  logic              out_of_range_flag = 1'b0;         // converter overrange
  adc_cfg_pkg::cfg_t cfg;                // settings out
  adc_cfg_pkg::cfg_t c;                  // expected settings
  logic              ob, cm, coe, ccoe;  // format, clock enables
  logic              ovr_q, ovr_oe, cmi; // flag, common mode
  logic [7:0]        rise, fall, loe;    // lane outputs
  logic [15:0]       cdat, cdoe;         // parallel outputs
  int                mismatches = 0;     // failed compares
  int                n_checks = 0;       // all compares
  logic [7:0]        v7e [4] = '{8'h01, 8'h26, 8'hfc, 8'h5b}; // buffer settings
  logic [2:0]        pins [4] = '{3'h5, 3'h2, 3'h7, 3'h0};    // static levels

  adc_config_and_pin_control i_adc_config_and_pin_control (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .sclk_in(sclk),
    .ser_reset_in(rst_pin), .serial_shift_data_in(serial_shift_data),
    .serial_frame_select_n_in(sen_n), .out_enable_in(oe),
    .format_and_interface_select_in(fmt), .ref_mode_pin_in(mode_pin),
    .sample_in(smp), .sample_ovr_in(out_of_range_flag), .cfg_out(cfg), .offset_binary_out(ob),
    .cmos_mode_out(cm), .ddr_lane_rise_out(rise), .ddr_lane_fall_out(fall),
    .ddr_lane_oe_out(loe), .cmos_data_out(cdat), .cmos_data_oe_out(cdoe),
    .clk_out_oe_out(coe), .clk_out_comp_oe_out(ccoe), .out_of_range_flag_out(ovr_q),
    .out_of_range_flag_oe_out(ovr_oe), .common_mode_pin_is_input_out(cmi)
  );

  host_serial_model i_host_serial_model (
    .sclk_out(sclk), .serial_shift_data_out(serial_shift_data), .sen_n_out(sen_n), .rst_pin_out(rst_pin)
  );

  // system clock, 5 ns period
  initial begin
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  // compare and count
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // expected settings from register contents
  function automatic adc_cfg_pkg::cfg_t mk(input logic rf, input logic [7:0] b,
                                           input logic [7:0] m);
    adc_cfg_pkg::cfg_t r;
    r = '0;
    r.ext_ref = rf;
    r.curr_code = b[1:0];
    r.clk_term = b[4:2];
    r.data_term = b[7:5];
    r.data_scale = {1'b0, m[6]};
    r.clk_scale = (m[7:6] == 2'h3) ? 2'h2 : {1'b0, |m[7:6]};
    return r;
  endfunction : mk

  // bounded wait for settings, then compare
  task automatic chk_cfg(input adc_cfg_pkg::cfg_t e, input logic [15:0] m);
    for (int i = 0; i < 60 && (cfg & m) !== (e & m); i++) begin
      @(posedge clk_sys_in);
    end
    repeat (2) @(posedge clk_sys_in);
    #1;
    chk("cfg_out", e & m, cfg & m);
    chk("common_mode_pin_is_input_out", 16'(e.ext_ref), 16'(cmi));
  endtask : chk_cfg

  // one serial register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host_serial_model.write_reg(a, d);
  endtask : wr

  // drive the output stage inputs and inspect it
  task automatic out_case(input logic f, input logic e, input logic [15:0] s, input logic v);
    logic [7:0] er, ef;
    @(posedge clk_sys_in);
    fmt <= f;
    oe <= e;
    smp <= s;
    out_of_range_flag <= v;
    repeat (8) @(posedge clk_sys_in);
    #1;
    for (int i = 0; i < 8; i++) begin
      er[i] = s[2*i];
      ef[i] = s[2*i+1];
    end
    ef[7] = s[15] ^ f;
    chk("cmos_mode_out", 16'(f), 16'(cm));
    chk("offset_binary_out", 16'(f), 16'(ob));
    chk("ddr_lane_oe_out", 16'({8{e & ~f}}), 16'(loe));
    chk("cmos_data_oe_out", {16{e & f}}, cdoe);
    chk("clk_out_oe_out", 16'(e), 16'(coe));
    chk("clk_out_comp_oe_out", 16'(e & ~f), 16'(ccoe));
    chk("out_of_range_flag_oe_out", 16'(e), 16'(ovr_oe));
    chk("out_of_range_flag_out", 16'(v), 16'(ovr_q));
    // msb inverted for offset binary
    if (e && !f) begin
      chk("ddr_lane_rise_out", 16'(er), 16'(rise));
      chk("ddr_lane_fall_out", 16'(ef), 16'(fall));
    end
    if (e && f) begin
      chk("cmos_data_out", {s[15] ^ f, s[14:0]}, cdat);
    end
  endtask : out_case

  // verdict and end of run
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  // watchdog, far beyond the expected 22 us
  initial begin
    #200000;
    mismatches++;
    end_of_test();
  end

  // main sequence
  initial begin
    repeat (4) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    i_host_serial_model.pulse_reset();
    chk_cfg(mk(1'b0, 8'h00, 8'h00), 16'hfff8);
    foreach (v7e[i]) begin
      wr(8'h7e, v7e[i]);
      chk_cfg(mk(1'b0, v7e[i], 8'h00), 16'hfff8);
    end
    for (int k = 0; k < 4; k++) begin
      wr(8'h7f, {2'(k), 6'h00});
      chk_cfg(mk(1'b0, 8'h5b, {2'(k), 6'h00}), 16'hfff8);
    end
    wr(8'h6d, 8'h10);
    chk_cfg(mk(1'b1, 8'h5b, 8'hc0), 16'hfff8);
    // two words in one frame, then a cut byte
    i_host_serial_model.open_frame();
    i_host_serial_model.write_word(8'h7e, 8'ha5);
    i_host_serial_model.write_word(8'h7f, 8'h40);
    i_host_serial_model.shift_byte(8'h7e);
    i_host_serial_model.close_frame();
    chk_cfg(mk(1'b1, 8'ha5, 8'h40), 16'hfff8);
    // unmapped address leaves all alone
    wr(8'h70, 8'hff);
    chk_cfg(mk(1'b1, 8'ha5, 8'h40), 16'hfff8);
    // slow host
    i_host_serial_model.half_ns = 120;
    wr(8'h7e, 8'h3a);
    i_host_serial_model.half_ns = 24;
    chk_cfg(mk(1'b1, 8'h3a, 8'h40), 16'hfff8);
    wr(8'h6e, 8'h01);
    chk_cfg(mk(1'b0, 8'h00, 8'h00), 16'hfff8);
    // later writes stick once the trigger is clear
    wr(8'h7e, 8'h22);
    chk_cfg(mk(1'b0, 8'h22, 8'h00), 16'hfff8);
    wr(8'h7f, 8'hc0);
    i_host_serial_model.pulse_reset();
    chk_cfg(mk(1'b0, 8'h00, 8'h00), 16'hfff8);
    // static pin mode overrides registers
    wr(8'h6d, 8'h10);
    wr(8'h7e, 8'hff);
    foreach (pins[i]) begin
      @(posedge clk_sys_in);
      mode_pin <= pins[i][0] ^ pins[i][1];
      i_host_serial_model.set_static(pins[i][2], pins[i][1], pins[i][0]);
      c = mk(pins[i][0] ^ pins[i][1], 8'h00, 8'h00);
      c.low_rate = pins[i][2];
      c.standby = pins[i][1];
      c.clk_edge_alt = pins[i][0];
      chk_cfg(c, 16'hffff);
    end
    i_host_serial_model.leave_static();
    wr(8'h7e, 8'h01);
    chk_cfg(mk(1'b0, 8'h01, 8'h00), 16'hfff8);
    out_case(1'b0, 1'b1, 16'h5a3c, 1'b1);
    out_case(1'b1, 1'b1, 16'h3c5a, 1'b0);
    out_case(1'b1, 1'b0, 16'h1234, 1'b1);
    out_case(1'b0, 1'b0, 16'h7edb, 1'b0);
    end_of_test();
  end
endmodule : adc_config_and_pin_control_tb

// ---- bit_sync.sv ----
// two flip-flop level synchroniser
`timescale 1ns/1ps
module bit_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic d_in,
  output logic      q_out
);
  logic meta_r;  // first stage, read only by second
  // two stage capture
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_r <= RST_VAL;
      q_out  <= RST_VAL;
    end else begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end
endmodule : bit_sync

// ---- host_serial_model.sv ----
// host controller model driving the serial configuration pins
`timescale 1ns/1ps
module host_serial_model (
  output logic sclk_out,
  output logic serial_shift_data_out,
  output logic sen_n_out,
  output logic rst_pin_out
);
  int half_ns = 24;  // shift clock half period, 48 ns clock

  // idle levels follow the pin pulls
  initial begin
    sclk_out = 1'b0;
    serial_shift_data_out = 1'b0;
    sen_n_out = 1'b1;
    rst_pin_out = 1'b0;
  end

  task automatic shift_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      serial_shift_data_out = v[i];
      sclk_out = 1'b1;
      #(half_ns);
      sclk_out = 1'b0;
      #(half_ns);
    end
  endtask : shift_byte

  // select low with setup
  task automatic open_frame();
    sen_n_out = 1'b0;
    #30;
  endtask : open_frame

  // release select, data to pull level
  task automatic close_frame();
    #30;
    sen_n_out = 1'b1;
    serial_shift_data_out = 1'b0;
    #100;
  endtask : close_frame

  task automatic write_word(input logic [7:0] a, input logic [7:0] d);
    shift_byte(a);
    shift_byte(d);
  endtask : write_word

  // one word in a frame of its own
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    open_frame();
    write_word(a, d);
    close_frame();
  endtask : write_reg

  // short high pulse on reset pin
  task automatic pulse_reset();
    rst_pin_out = 1'b1;
    #40;
    rst_pin_out = 1'b0;
    #100;
  endtask : pulse_reset

  // reset pin held high, pins static
  task automatic set_static(input logic lr, input logic sb, input logic ed);
    rst_pin_out = 1'b1;
    sclk_out = lr;
    serial_shift_data_out = sb;
    sen_n_out = ed;
    #100;
  endtask : set_static

  // pins back to serial idle
  task automatic leave_static();
    sclk_out = 1'b0;
    serial_shift_data_out = 1'b0;
    sen_n_out = 1'b1;
    #20;
    rst_pin_out = 1'b0;
    #100;
  endtask : leave_static
endmodule : host_serial_model

// ---- serial_shift.sv ----
// serial shifter on the link clock, emits words by toggle crossing
`timescale 1ns/1ps
module serial_shift (
  input  wire logic                   sclk_in,
  input  wire logic                   rst_b_in,
  input  wire logic                   serial_frame_select_n_in,
  input  wire logic                   serial_shift_data_in,
  output adc_cfg_pkg::ser_word_t      word_out,
  output logic                        word_tgl_out
);
  logic [14:0] shift_r;  // partial word
  logic [3:0]  cnt_r;    // bits taken in this word

  // sample on falling edge; select high resets the count
  always_ff @(negedge sclk_in or posedge serial_frame_select_n_in) begin
    if (serial_frame_select_n_in) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  // shift data in, address first
  always_ff @(negedge sclk_in) begin
    if (!serial_frame_select_n_in) begin
      shift_r <= {shift_r[13:0], serial_shift_data_in};
    end
  end

  // sixteenth bit completes address and data
  // system reset clears the toggle so no false word follows reset
  always_ff @(negedge sclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      word_out     <= '0;
      word_tgl_out <= 1'b0;
    end else if (!serial_frame_select_n_in && cnt_r == 4'hf) begin
      word_out     <= {shift_r, serial_shift_data_in};
      word_tgl_out <= ~word_tgl_out;
    end
  end
endmodule : serial_shift
